// >>> verilog/cbsc_ctrl.sv
// SMBus slave, control bytes and output pair gating of the clock buffer.
`timescale 1ns/1ns
`default_nettype none
`include "cbsc_regs.svh"

module cbsc_ctrl (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_oe0,
    input wire logic i_oe3,
    input wire logic i_control_polarity_select,
    input wire logic i_clock_stop_n,
    input wire logic i_power_down_n,
    input wire logic i_pll_mode_pin,
    input wire logic i_loop_bandwidth_select,
    output logic [3:0] o_pair_run,
    output logic [3:0] o_pair_float,
    output logic o_div_normal,
    output logic o_pll_mode,
    output logic o_low_bw
);
    import cbsc_pkg::*;

    cbsc_ctrl_s s_r;
    cbsc_ctrl_s s_nxt;
    cbsc_pins_s pins;
    cbsc_bus_s bus;

    cbsc_pin_cond u_pins (
        .i_control_polarity_select(i_control_polarity_select),
        .i_oe0(i_oe0),
        .i_oe3(i_oe3),
        .i_clock_stop_n(i_clock_stop_n),
        .i_power_down_n(i_power_down_n),
        .o_pins(pins)
    );

    cbsc_bus_edge u_edge (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_bus(bus)
    );

    function automatic logic [7:0] rd_reg(input cbsc_ctrl_s s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `CBSC_IDX_MODE: v = s.mode;
            `CBSC_IDX_ENABLE: v = s.enable;
            `CBSC_IDX_STOPMASK: v = s.stopmask;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : rd_reg

    function automatic int pair_bit(input int i);
        int b;
        b = `CBSC_B_PAIR3;
        unique case (i)
            0: b = `CBSC_B_PAIR0;
            1: b = `CBSC_B_PAIR1;
            2: b = `CBSC_B_PAIR2;
            default: b = `CBSC_B_PAIR3;
        endcase
        return b;
    endfunction : pair_bit

    always_comb begin
        logic [7:0] b;
        logic stopped;
        logic pin_ok;
        b = 8'h00;
        stopped = 1'b0;
        pin_ok = 1'b1;
        s_nxt = s_r;
        // Power-down wins over bus activity because the host leaves the lines floating.
        if (pins.pd || bus.stop) begin
            s_nxt.st = ST_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else if (bus.start) begin
            s_nxt.st = ST_RX;
            s_nxt.ph = PH_ADDR;
            s_nxt.bitcnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
        end else begin
            unique case (s_r.st)
                ST_IDLE: begin
                end
                ST_RX: begin
                    if (bus.scl_rise && s_r.bitcnt != `CBSC_BYTE_BITS) begin
                        s_nxt.shreg = {s_r.shreg[6:0], bus.sda};
                        s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
                    end else if (bus.scl_fall && s_r.bitcnt == `CBSC_BYTE_BITS) begin
                        b = s_r.shreg;
                        s_nxt.bitcnt = 4'h0;
                        s_nxt.st = ST_ACK_OUT;
                        s_nxt.sda_oe = 1'b1;
                        unique case (s_r.ph)
                            PH_ADDR: begin
                                if (b[7:1] == `CBSC_SLAVE_ADDR) begin
                                    s_nxt.rw = b[0];
                                    s_nxt.ph = b[0] ? PH_RCOUNT : PH_OFFSET;
                                end else begin
                                    s_nxt.st = ST_IDLE;
                                    s_nxt.sda_oe = 1'b0;
                                end
                            end
                            PH_OFFSET: begin
                                s_nxt.index = b;
                                s_nxt.ph = PH_COUNT;
                            end
                            PH_COUNT: begin
                                s_nxt.count = b;
                                s_nxt.ph = PH_DATA;
                            end
                            PH_DATA: begin
                                if (s_r.count != 8'h00) begin
                                    unique case (s_r.index)
                                        `CBSC_IDX_MODE: s_nxt.mode = b & `CBSC_MASK_MODE;
                                        `CBSC_IDX_ENABLE: s_nxt.enable = b & `CBSC_MASK_ENABLE;
                                        `CBSC_IDX_STOPMASK: s_nxt.stopmask = b & `CBSC_MASK_STOPMASK;
                                        default: begin
                                        end
                                    endcase
                                    s_nxt.index = 8'(s_r.index + 8'h01);
                                    s_nxt.count = 8'(s_r.count - 8'h01);
                                end else begin
                                    // Bytes beyond the announced count are refused.
                                    s_nxt.st = ST_IDLE;
                                    s_nxt.sda_oe = 1'b0;
                                end
                            end
                            default: begin
                                s_nxt.st = ST_IDLE;
                                s_nxt.sda_oe = 1'b0;
                            end
                        endcase
                    end
                end
                ST_ACK_OUT: begin
                    if (bus.scl_fall) begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = ST_RX;
                        if (s_r.ph == PH_RCOUNT) begin
                            // A read opens with the number of bytes that can be read.
                            b = `CBSC_REG_NUM;
                            s_nxt.st = ST_TX;
                            s_nxt.shreg = b;
                            s_nxt.sda_oe = ~b[7];
                            s_nxt.ph = PH_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (bus.scl_fall) begin
                        if (s_r.bitcnt == `CBSC_LAST_BIT) begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.bitcnt = 4'h0;
                            s_nxt.st = ST_ACK_IN;
                        end else begin
                            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.shreg[6];
                            s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
                        end
                    end
                end
                ST_ACK_IN: begin
                    if (bus.scl_rise) begin
                        s_nxt.st = bus.sda ? ST_IDLE : ST_ACK_WAIT;
                    end
                end
                ST_ACK_WAIT: begin
                    if (bus.scl_fall) begin
                        b = rd_reg(s_r, s_r.index);
                        s_nxt.shreg = b;
                        s_nxt.sda_oe = ~b[7];
                        s_nxt.index = 8'(s_r.index + 8'h01);
                        s_nxt.st = ST_TX;
                    end
                end
            endcase
        end
        for (int i = 0; i < 4; i++) begin
            pin_ok = (i == 0) ? pins.en0 : ((i == 3) ? pins.en3 : 1'b1);
            stopped = pins.pd | (pins.stop & s_r.stopmask[pair_bit(i)]);
            s_nxt.out.pair_run[i] = s_r.enable[pair_bit(i)] & pin_ok & ~stopped;
            s_nxt.out.pair_float[i] = pins.pd ? s_r.mode[`CBSC_B_PD_FLOAT]
                : (stopped & s_r.mode[`CBSC_B_STOP_FLOAT]);
        end
        s_nxt.out.div_normal = s_r.mode[`CBSC_B_DIV_NORMAL];
        s_nxt.out.pll_mode = s_r.mode[`CBSC_B_PLL_MODE] & i_pll_mode_pin;
        s_nxt.out.low_bw = s_r.mode[`CBSC_B_LOW_BW] & i_loop_bandwidth_select;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '{st: ST_IDLE, ph: PH_ADDR, bitcnt: 4'h0, shreg: 8'h00, index: 8'h00,
                     count: 8'h00, rw: 1'b0, sda_oe: 1'b0, mode: `CBSC_RST_MODE,
                     enable: `CBSC_RST_ENABLE, stopmask: `CBSC_RST_STOPMASK,
                     out: '{pair_run: 4'h0, pair_float: 4'h0, div_normal: 1'b1,
                            pll_mode: 1'b0, low_bw: 1'b0}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // The data line is open-drain, so the driven level is always low.
    assign o_sda = 1'b0;
    assign o_sda_oe = s_r.sda_oe;
    assign o_pair_run = s_r.out.pair_run;
    assign o_pair_float = s_r.out.pair_float;
    assign o_div_normal = s_r.out.div_normal;
    assign o_pll_mode = s_r.out.pll_mode;
    assign o_low_bw = s_r.out.low_bw;

    a_addr_mismatch: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_r.st == ST_RX && s_r.ph == PH_ADDR && bus.scl_fall && !bus.start && !bus.stop
         && !pins.pd && s_r.bitcnt == `CBSC_BYTE_BITS && s_r.shreg[7:1] != `CBSC_SLAVE_ADDR)
        |=> (s_r.st == ST_IDLE && !o_sda_oe))
        else $error("Foreign address was acknowledged.");

    a_ack_held: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(s_r.st == ST_ACK_OUT) |-> o_sda_oe throughout (s_r.st == ST_ACK_OUT)[*2])
        else $error("Acknowledge bit not driven low.");

    a_read_count: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_r.st == ST_ACK_OUT && s_r.ph == PH_RCOUNT && bus.scl_fall && !bus.start
         && !bus.stop && !pins.pd) |=> (s_r.st == ST_TX && s_r.shreg == `CBSC_REG_NUM))
        else $error("Read did not open with the byte count.");

    a_index_advance: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_r.st == ST_ACK_WAIT && bus.scl_fall && !bus.start && !bus.stop && !pins.pd)
        |=> (s_r.index == 8'($past(s_r.index) + 8'h01)
             && s_r.shreg == rd_reg(s_r, $past(s_r.index))))
        else $error("Read index did not advance.");

    a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        ((s_r.mode & ~`CBSC_MASK_MODE) == 8'h00) && ((s_r.enable & ~`CBSC_MASK_ENABLE) == 8'h00)
        && ((s_r.stopmask & ~`CBSC_MASK_STOPMASK) == 8'h00))
        else $error("Reserved bit holds a one.");

    a_div_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        $changed(s_r.mode[`CBSC_B_DIV_NORMAL])
        |=> o_div_normal == $past(s_r.mode[`CBSC_B_DIV_NORMAL]))
        else $error("Output mode did not follow the control byte.");

    a_pll_select: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_pll_mode_pin |=> !o_pll_mode)
        else $error("Fanout pin did not force bypass.");

    a_bw_select: assert property (@(posedge i_clk) disable iff (i_rst)
        (!s_r.mode[`CBSC_B_LOW_BW] || !i_loop_bandwidth_select) |=> !o_low_bw)
        else $error("High bandwidth request ignored.");

    a_pd_outputs: assert property (@(posedge i_clk) disable iff (i_rst)
        pins.pd |=> (o_pair_run == 4'h0
                     && o_pair_float == {4{$past(s_r.mode[`CBSC_B_PD_FLOAT])}}))
        else $error("Power-down left a pair running.");

    a_stop_mask: assert property (@(posedge i_clk) disable iff (i_rst)
        (pins.stop && !pins.pd && s_r.stopmask[`CBSC_B_PAIR1]) |=> !o_pair_run[1])
        else $error("Masked pair kept running under clock-stop.");

    a_free_run: assert property (@(posedge i_clk) disable iff (i_rst)
        (!pins.pd && !s_r.stopmask[`CBSC_B_PAIR2] && s_r.enable[`CBSC_B_PAIR2])
        |=> o_pair_run[2])
        else $error("Unmasked enabled pair was stopped.");

    a_reg_enable: assert property (@(posedge i_clk) disable iff (i_rst)
        !s_r.enable[`CBSC_B_PAIR0] |=> !o_pair_run[0])
        else $error("Disabled pair is running.");

    a_pin_enable: assert property (@(posedge i_clk) disable iff (i_rst)
        ((i_oe3 == i_control_polarity_select) |=> !o_pair_run[3]))
        else $error("Pin-disabled pair is running.");

    a_pin_polarity: assert property (@(posedge i_clk) disable iff (i_rst)
        pins.pd == (i_power_down_n == i_control_polarity_select))
        else $error("Power-down polarity wrong.");

    a_pd_bus_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        pins.pd |=> (s_r.st == ST_IDLE && !o_sda_oe))
        else $error("Bus active during power-down.");

    c_write_data: cover property (@(posedge i_clk) disable iff (i_rst)
        s_r.st == ST_RX && s_r.ph == PH_DATA && s_r.count != 8'h00 ##1 s_r.st == ST_ACK_OUT);
    c_read_data: cover property (@(posedge i_clk) disable iff (i_rst)
        s_r.st == ST_ACK_WAIT ##1 s_r.st == ST_TX);
    c_stop_float: cover property (@(posedge i_clk) disable iff (i_rst)
        o_pair_float != 4'h0 && !pins.pd);

endmodule : cbsc_ctrl

`default_nettype wire

// >>> verilog/cbsc_regs.svh
// Register indices, bit positions, reset values and bus constants of the clock buffer control.
`ifndef CBSC_REGS_SVH
`define CBSC_REGS_SVH

`define CBSC_SLAVE_ADDR 7'h6e
`define CBSC_BYTE_BITS 4'h8
`define CBSC_LAST_BIT 4'h7

`define CBSC_IDX_MODE 8'h00
`define CBSC_IDX_ENABLE 8'h01
`define CBSC_IDX_STOPMASK 8'h02
`define CBSC_REG_NUM 8'h03

`define CBSC_RST_MODE 8'h07
`define CBSC_RST_ENABLE 8'h66
`define CBSC_RST_STOPMASK 8'h00

`define CBSC_MASK_MODE 8'hc7
`define CBSC_MASK_ENABLE 8'h66
`define CBSC_MASK_STOPMASK 8'h66

`define CBSC_B_DIV_NORMAL 0
`define CBSC_B_PLL_MODE 1
`define CBSC_B_LOW_BW 2
`define CBSC_B_STOP_FLOAT 6
`define CBSC_B_PD_FLOAT 7

`define CBSC_B_PAIR0 1
`define CBSC_B_PAIR1 2
`define CBSC_B_PAIR2 5
`define CBSC_B_PAIR3 6

`endif

// >>> verilog/cbsc_pkg.sv
// Types shared by the clock buffer control modules.
package cbsc_pkg;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK_OUT, ST_TX, ST_ACK_IN, ST_ACK_WAIT} cbsc_state_e;

    typedef enum logic [2:0] {PH_ADDR, PH_OFFSET, PH_COUNT, PH_DATA, PH_RCOUNT} cbsc_phase_e;

    typedef struct packed {
        logic en0;
        logic en3;
        logic stop;
        logic pd;
    } cbsc_pins_s;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } cbsc_bus_s;

    typedef struct packed {
        logic scl_q;
        logic sda_q;
    } cbsc_edge_s;

    typedef struct packed {
        logic [3:0] pair_run;
        logic [3:0] pair_float;
        logic div_normal;
        logic pll_mode;
        logic low_bw;
    } cbsc_out_s;

    typedef struct packed {
        cbsc_state_e st;
        cbsc_phase_e ph;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] index;
        logic [7:0] count;
        logic rw;
        logic sda_oe;
        logic [7:0] mode;
        logic [7:0] enable;
        logic [7:0] stopmask;
        cbsc_out_s out;
    } cbsc_ctrl_s;

endpackage : cbsc_pkg

// >>> verilog/cbsc_pin_cond.sv
// Polarity handling of the enable, clock-stop and power-down pins.
`timescale 1ns/1ns
`default_nettype none

module cbsc_pin_cond (
    input wire logic i_control_polarity_select,
    input wire logic i_oe0,
    input wire logic i_oe3,
    input wire logic i_clock_stop_n,
    input wire logic i_power_down_n,
    output var cbsc_pkg::cbsc_pins_s o_pins
);
    import cbsc_pkg::*;

    // Each field of o_pins is true when its function is requested.
    always_comb begin
        o_pins.en0 = i_oe0 ^ i_control_polarity_select;
        o_pins.en3 = i_oe3 ^ i_control_polarity_select;
        o_pins.stop = ~(i_clock_stop_n ^ i_control_polarity_select);
        o_pins.pd = ~(i_power_down_n ^ i_control_polarity_select);
    end

endmodule : cbsc_pin_cond

`default_nettype wire

// >>> verilog/cbsc_bus_edge.sv
// Edge, start and stop detection on the serial clock and data lines.
`timescale 1ns/1ns
`default_nettype none

module cbsc_bus_edge (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output var cbsc_pkg::cbsc_bus_s o_bus
);
    import cbsc_pkg::*;

    cbsc_edge_s s_r;
    cbsc_edge_s s_nxt;

    always_comb begin
        s_nxt.scl_q = i_scl;
        s_nxt.sda_q = i_sda;
        o_bus.scl_rise = i_scl & ~s_r.scl_q;
        o_bus.scl_fall = ~i_scl & s_r.scl_q;
        // Data moving while the clock stays high marks a frame boundary.
        o_bus.start = i_scl & s_r.scl_q & s_r.sda_q & ~i_sda;
        o_bus.stop = i_scl & s_r.scl_q & ~s_r.sda_q & i_sda;
        o_bus.sda = i_sda;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '{scl_q: 1'b1, sda_q: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : cbsc_bus_edge

`default_nettype wire

// >>> verif/cbsc_host_model.sv
// SMBus host model that drives the serial clock and pulls the data line low.
`timescale 1ns/1ns
`default_nettype none

module cbsc_host_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output var logic o_scl,
    output var logic o_sda_low
);
    // Cycles per wait step (low phase two steps, high phase one); the bench raises it to act as a slow host.
    int half = 4;

    // Both lines are released while idle, so power-down never sees them driven.
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic wt();
        repeat (half) @(negedge i_clk);
    endtask : wt

    // Data changes only in the middle of the low phase and is read late in the high phase.
    task automatic bit_slot(input logic b, output logic s);
        wt();
        o_sda_low = ~b;
        wt();
        o_scl = 1'b1;
        wt();
        s = i_sda;
        o_scl = 1'b0;
    endtask : bit_slot

    // Serves as start and as repeated start.
    task automatic start();
        o_sda_low = 1'b0;
        wt();
        o_scl = 1'b1;
        wt();
        o_sda_low = 1'b1;
        wt();
        o_scl = 1'b0;
    endtask : start

    task automatic stop();
        wt();
        o_sda_low = 1'b1;
        wt();
        o_scl = 1'b1;
        wt();
        o_sda_low = 1'b0;
        wt();
    endtask : stop

    task automatic wr_byte(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], s);
        end
        bit_slot(1'b1, nack);
    endtask : wr_byte

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, d[i]);
        end
        bit_slot(nack, s);
    endtask : rd_byte
endmodule : cbsc_host_model
`default_nettype wire

// >>> verif/cbsc_ctrl_bench.sv
// Self-checking bench of the clock buffer control with an SMBus host model.
`timescale 1ns/1ns
`default_nettype none

module cbsc_ctrl_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic host_low;
    logic sda;
    logic sda_o;
    logic sda_oe;
    logic oe0 = 1'b1;
    logic oe3 = 1'b1;
    logic pol = 1'b0;
    logic stop_n = 1'b1;
    logic pd_n = 1'b1;
    logic pll_pin = 1'b1;
    logic bw_pin = 1'b1;
    logic [3:0] run;
    logic [3:0] flt;
    logic dnorm;
    logic pll;
    logic lbw;
    logic [7:0] sm = 8'h07;
    logic [7:0] se = 8'h66;
    logic [7:0] ss = 8'h00;
    int err_total = 0;
    int checks_done = 0;

    always #25 clk = ~clk;

    // The data line has a pull-up; either party may only pull it low.
    assign sda = ~(host_low | (sda_oe & ~sda_o));

    cbsc_host_model i_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

    cbsc_ctrl i_dut (.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda(sda_o),
        .o_sda_oe(sda_oe), .i_oe0(oe0), .i_oe3(oe3), .i_control_polarity_select(pol),
        .i_clock_stop_n(stop_n), .i_power_down_n(pd_n), .i_pll_mode_pin(pll_pin),
        .i_loop_bandwidth_select(bw_pin), .o_pair_run(run), .o_pair_float(flt),
        .o_div_normal(dnorm), .o_pll_mode(pll), .o_low_bw(lbw));

    task automatic chk_byte(input string nm, input logic [7:0] ex, input logic [7:0] got);
        checks_done++;
        if (got !== ex) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk_byte

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // Run and float of each pair from the pins and the shadow copies of the control bytes.
    function automatic logic [7:0] pairs_exp();
        logic stp;
        logic pdn;
        logic [3:0] en;
        logic [3:0] hit;
        stp = ~(stop_n ^ pol);
        pdn = ~(pd_n ^ pol);
        en = {se[6], se[5], se[2], se[1]} & {oe3 ^ pol, 2'b11, oe0 ^ pol};
        hit = {ss[6], ss[5], ss[2], ss[1]} & {4{stp}};
        // A stopped pair floats by the mode byte alone, whether or not it is enabled.
        return {en & ~{4{pdn}} & ~hit, pdn ? {4{sm[7]}} : hit & {4{sm[6]}}};
    endfunction : pairs_exp

    task automatic chk_outs();
        repeat (2) @(negedge clk);
        chk_byte("pairs", pairs_exp(), {run, flt});
        chk_byte("mode", {5'h00, sm[0], sm[1] & pll_pin, sm[2] & bw_pin},
                 {5'h00, dnorm, pll, lbw});
    endtask : chk_outs

    // Indexed block write; m data bytes are sent after a count of n.
    task automatic wr(input logic [7:0] off, input logic [7:0] n, input logic [23:0] d,
                      input int m, output logic [5:0] nk);
        nk = 6'h00;
        i_host.start();
        i_host.wr_byte(8'hdc, nk[0]);
        i_host.wr_byte(off, nk[1]);
        i_host.wr_byte(n, nk[2]);
        for (int k = 0; k < m; k++) begin
            i_host.wr_byte(d[23 - 8 * k -: 8], nk[3 + k]);
        end
        i_host.stop();
    endtask : wr

    // Indexed block read of three bytes after the count byte.
    task automatic rd(input logic [7:0] off, input logic [23:0] ex);
        logic [2:0] nk;
        logic [7:0] c;
        logic [23:0] d;
        i_host.start();
        i_host.wr_byte(8'hdc, nk[0]);
        i_host.wr_byte(off, nk[1]);
        i_host.start();
        i_host.wr_byte(8'hdd, nk[2]);
        i_host.rd_byte(1'b0, c);
        i_host.rd_byte(1'b0, d[23:16]);
        i_host.rd_byte(1'b0, d[15:8]);
        i_host.rd_byte(1'b1, d[7:0]);
        i_host.stop();
        chk_byte("read acks", 8'h00, {5'h00, nk});
        chk_byte("read count", 8'h03, c);
        for (int k = 0; k < 3; k++) begin
            chk_byte("read data", ex[23 - 8 * k -: 8], d[23 - 8 * k -: 8]);
        end
    endtask : rd

    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        $display("[FAIL] watchdog expected done seen running");
        conclude();
    end

    initial begin
        logic [5:0] nk;
        logic a;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk_outs();
        rd(8'h00, 24'h076600);
        $display("test reset values done");

        wr(8'h00, 8'h03, 24'hffffff, 3, nk);
        chk_byte("write acks", 8'h00, {2'h0, nk});
        sm = 8'hc7;
        ss = 8'h66;
        rd(8'h00, 24'hc76666);
        chk_outs();
        $display("test block write done");

        for (int k = 0; k < 32; k++) begin
            {pol, oe0, oe3, stop_n, pd_n} = k[4:0];
            {pll_pin, bw_pin} = k[1:0];
            chk_outs();
        end
        {pol, oe0, oe3, stop_n, pd_n, pll_pin, bw_pin} = 7'b0111111;
        chk_outs();
        $display("test pin control done");

        // A slow host that also sends one byte more than its count.
        i_host.half = 8;
        wr(8'h00, 8'h01, 24'h00ff00, 2, nk);
        i_host.half = 4;
        chk_byte("count overrun acks", 8'h10, {2'h0, nk});
        sm = 8'h00;
        chk_outs();
        rd(8'h00, 24'h006666);
        $display("test count overrun done");

        i_host.start();
        i_host.wr_byte(8'hde, a);
        i_host.stop();
        chk_byte("foreign address ack", 8'h01, {7'h00, a});
        $display("test foreign address done");

        wr(8'h02, 8'h02, 24'h00aa00, 2, nk);
        chk_byte("past end acks", 8'h00, {2'h0, nk});
        ss = 8'h00;
        rd(8'h01, 24'h660000);
        $display("test past end done");
        conclude();
    end
endmodule : cbsc_ctrl_bench
`default_nettype wire
